// File: verilog/bqc_counter.sv
// bcd / bi-quinary ripple counter with two falling-edge section clocks
`timescale 1ns/10ps
`default_nettype none
`include "bqc_consts.svh"

// Operation
// - BCD mode steps bits 3..0 through 0 to 9 per falling edge, then 0.
// - Bi-quinary: bits 3..1 cycle 0..4; bit0 toggles every five input edges.
// - High clear_in forces all outputs low at once; counting only while low.
// - Separate divide-by-2 and divide-by-5 sections for products of 2 and 5.

module bqc_counter
	import bqc_pkg::*;
#(
	parameter int QUIN_MOD = `BQC_QUIN_MOD
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// section clocks and clear
	input  wire logic div2_clock,
	input  wire logic div5_clock,
	input  wire logic clear_in,
	// count outputs
	output var  logic count_bit0,
	output var  logic count_bit1,
	output var  logic count_bit2,
	output var  logic count_bit3
);

	////////////////////////////////////////////////////////////////////////////////
	// elaboration check

	// the quinary section has three bits, so the modulus must fit in them
	if (QUIN_MOD < 2 || QUIN_MOD > 8) begin : g_bad_mod
		$error("QUIN_MOD must lie between 2 and 8");
	end

	localparam logic [2:0] QUIN_LAST = 3'(QUIN_MOD - 1);

	////////////////////////////////////////////////////////////////////////////////
	// falling-edge detection on the section clocks
	// a section clock must stand one full clk cycle high and then low;
	// shorter pulses fall between samples and are lost

	bqc_edge_t  edge_reg;
	bqc_edge_t  edge_next;
	logic       div2_fall;
	logic       div5_fall;

	always_comb begin
		edge_next.div2 = div2_clock;
		edge_next.div5 = div5_clock;
	end

	// only rst clears the edge history: clear_in must not fake a falling edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			edge_reg <= '{div2: `BQC_EDGE_RESET, div5: `BQC_EDGE_RESET};
		end else begin
			edge_reg <= edge_next;
		end
	end

	assign div2_fall = edge_reg.div2 & ~div2_clock;
	assign div5_fall = edge_reg.div5 & ~div5_clock;

	////////////////////////////////////////////////////////////////////////////////
	// the two counting sections

	bqc_count_t count_reg;
	bqc_count_t count_next;

	always_comb begin
		count_next = count_reg;
		// divide-by-2 section
		if (div2_fall) begin
			count_next.bin = ~count_reg.bin;
		end
		// divide-by-5 section
		if (div5_fall) begin
			if (count_reg.quin >= QUIN_LAST) begin
				count_next.quin = `BQC_QUIN_RESET;
			end else begin
				count_next.quin = count_reg.quin + 3'h1;
			end
		end
	end

	// clear_in acts without the clock so outputs drop at once
	always_ff @(posedge clk or posedge rst or posedge clear_in) begin
		if (rst || clear_in) begin
			count_reg <= '{quin: `BQC_QUIN_RESET, bin: `BQC_BIN_RESET};
		end else begin
			count_reg <= count_next;
		end
	end

	// in bcd mode bit0 feeds div5_clock, so bits 3..1 trail bit0 by one cycle
	assign count_bit0 = count_reg.bin;
	assign count_bit1 = count_reg.quin[0];
	assign count_bit2 = count_reg.quin[1];
	assign count_bit3 = count_reg.quin[2];

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || clear_in);

	a_bin_toggles_fall: assert property (div2_fall |=> count_bit0 != $past(count_bit0))
		else $error("bit0 did not toggle on div2 fall");

	a_bin_holds_idle: assert property (!div2_fall |=> $stable(count_bit0))
		else $error("bit0 changed without div2 fall");

	a_quin_holds_idle: assert property (!div5_fall |=> $stable(count_reg.quin))
		else $error("bits 3..1 changed without div5 fall");

	a_quin_step_up: assert property (
		div5_fall && count_reg.quin < QUIN_LAST |=> count_reg.quin == $past(count_reg.quin) + 3'h1
	)
		else $error("quinary section did not step by one");

	a_quin_wrap_zero: assert property (
		div5_fall && count_reg.quin == QUIN_LAST |=> count_reg.quin == 3'h0
	)
		else $error("quinary section did not wrap to zero");

	a_quin_fall_moves: assert property (
		div5_fall |=> count_reg.quin != $past(count_reg.quin)
	)
		else $error("bits 3..1 held on a div5 fall");

	a_quin_in_range: assert property (count_reg.quin <= QUIN_LAST)
		else $error("quinary section out of range");

	// each section must ignore the other's clock
	a_bin_apart: assert property (div5_fall && !div2_fall |=> $stable(count_bit0))
		else $error("bit0 moved on a div5 fall alone");

	a_quin_apart: assert property (div2_fall && !div5_fall |=> $stable(count_reg.quin))
		else $error("bits 3..1 moved on a div2 fall alone");

	a_edge_follows_pin: assert property (
		1'b1 |=> edge_reg.div2 == $past(div2_clock) && edge_reg.div5 == $past(div5_clock)
	)
		else $error("edge history lost a section clock sample");

	////////////////////////////////////////////////////////////////////////////////
	// assertion helper: a one-hot ring of divide-by-5 falls

	// a rotating ring instead of a second adder keeps the check independent of the counter
	localparam logic [QUIN_MOD-1:0] RING_START = {{(QUIN_MOD - 1){1'b0}}, 1'b1};
	logic [QUIN_MOD-1:0] ring_reg;
	logic [QUIN_MOD-1:0] ring_next;

	always_comb begin
		ring_next = ring_reg;
		if (div5_fall) begin
			ring_next = {ring_reg[QUIN_MOD-2:0], ring_reg[QUIN_MOD-1]};
		end
	end

	// cleared like the count so both restart together
	always_ff @(posedge clk or posedge rst or posedge clear_in) begin
		if (rst || clear_in) begin
			ring_reg <= RING_START;
		end else begin
			ring_reg <= ring_next;
		end
	end

	a_quin_ring_match: assert property (ring_reg[count_reg.quin])
		else $error("quinary count differs from its fall ring");

	a_five_falls_one: assert property (
		div5_fall && count_reg.quin == QUIN_LAST ##1 (!div5_fall)[*1]
		|-> count_reg.quin == 3'h0
	)
		else $error("quinary section not at zero after wrap");

	a_clear_forces_low: assert property (
		@(posedge clk) disable iff (rst)
		clear_in && $past(clear_in) |-> {count_bit3, count_bit2, count_bit1, count_bit0} == 4'h0
	)
		else $error("outputs not low while clear held");

	a_clear_release_zero: assert property (
		@(posedge clk) disable iff (rst)
		$fell(clear_in) |-> {count_bit3, count_bit2, count_bit1, count_bit0} == 4'h0
	)
		else $error("outputs not zero at clear release");

	// clear is asynchronous, so the first edge that samples it already sees zero
	a_clear_zero_now: assert property (
		@(posedge clk) disable iff (rst)
		clear_in |-> {count_bit3, count_bit2, count_bit1, count_bit0} == 4'h0
	)
		else $error("outputs not low at first sampled clear");

	a_clear_no_count: assert property (
		@(posedge clk) disable iff (rst)
		clear_in |=> {count_bit3, count_bit2, count_bit1, count_bit0} == 4'h0
	)
		else $error("count advanced while clear high");

	////////////////////////////////////////////////////////////////////////////////
	// cover properties

	// counting and clear events, ending with the bi-quinary carry: a quinary wrap followed by a divide-by-2 fall
	c_bin_toggle: cover property (div2_fall ##[2:40] div2_fall);
	c_quin_wrap: cover property (div5_fall && count_reg.quin == QUIN_LAST);
	c_count_nine: cover property (count_bit3 && count_bit0 && !count_bit2 && !count_bit1);
	c_clear_mid: cover property (@(posedge clk) disable iff (rst) $rose(clear_in) && $past(count_bit0));
	c_biq_carry: cover property (div5_fall && count_reg.quin == QUIN_LAST ##1 div2_fall);

endmodule

`default_nettype wire

// File: pkg/bqc_consts.svh
// constants for the bcd / bi-quinary ripple counter
`ifndef BQC_CONSTS_SVH
`define BQC_CONSTS_SVH

`define BQC_QUIN_MOD      5
`define BQC_QUIN_WIDTH    3
`define BQC_QUIN_RESET    3'h0
`define BQC_BIN_RESET     1'h0
`define BQC_EDGE_RESET    1'h0

`endif

// File: pkg/bqc_pkg.sv
// types shared by the bcd / bi-quinary ripple counter
package bqc_pkg;

	// quinary section on bits 3..1, binary section on bit 0
	typedef struct packed {
		logic [2:0] quin;
		logic       bin;
	} bqc_count_t;

	// previous levels of the two section clocks
	typedef struct packed {
		logic div2;
		logic div5;
	} bqc_edge_t;

endpackage

// File: bench/bqc_link_model.sv
// far-side wiring that picks bcd or bi-quinary counting
`timescale 1ns/10ps
`default_nettype none
module bqc_link_model (
	// mode and input clock
	input  wire logic quin_first,
	input  wire logic in_clock,
	// counter side
	input  wire logic count_bit0,
	input  wire logic count_bit3,
	output logic      div2_clock,
	output logic      div5_clock
);
	assign div2_clock = quin_first ? count_bit3 : in_clock;
	assign div5_clock = quin_first ? in_clock : count_bit0;
endmodule
`default_nettype wire

// File: bench/test_bqc_counter.sv
// self-checking bench for the bcd / bi-quinary ripple counter
`timescale 1ns/10ps
`default_nettype none
module test_bqc_counter;
	import bqc_pkg::*;
	logic        clk, rst, in_clock, quin_first, clear_in;
	logic        div2_clock, div5_clock, b0, b1, b2, b3;
	logic [31:0] seed;
	int          n, error_cnt, checks;
	bqc_count_t  seen;
	assign seen = {b3, b2, b1, b0};
	bqc_link_model u_bqc_link_model (.quin_first(quin_first), .in_clock(in_clock),
		.count_bit0(b0), .count_bit3(b3), .div2_clock(div2_clock), .div5_clock(div5_clock));
	bqc_counter u_bqc_counter (.clk(clk), .rst(rst), .div2_clock(div2_clock),
		.div5_clock(div5_clock), .clear_in(clear_in), .count_bit0(b0), .count_bit1(b1),
		.count_bit2(b2), .count_bit3(b3));
	////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic bqc_count_t expect_of(input int k, input logic q);
		return q ? {3'(k % 5), k >= 5} : 4'(k);
	endfunction
	task automatic check(input string what, input bqc_count_t got, input bqc_count_t exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// one whole high-then-low cycle; cascade needs two edges after the fall
	task automatic pulse(input int high);
		@(posedge clk) in_clock <= 1'b1;
		repeat (high) @(posedge clk);
		in_clock <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		n = (n + 1) % 10;
	endtask
	// mode is switched under clear so the rewiring cannot count
	task automatic set_mode(input logic q);
		@(posedge clk) clear_in <= 1'b1;
		quin_first <= q;
		#1 check("clear", seen, 4'h0);
		repeat (2) @(posedge clk);
		clear_in <= 1'b0;
		n = 0;
	endtask
	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		in_clock = 1'b0;
		quin_first = 1'b0;
		clear_in = 1'b0;
		seed = 32'h2E398EF9;
		error_cnt = 0;
		checks = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int t = 0; t < 8; t++) begin
			set_mode(t[0]);
			// narrowest legal high phase first, then random widths
			pulse(1);
			check("narrow", seen, expect_of(n, t[0]));
			seed = xs(seed);
			repeat (12 + seed[3:0]) begin
				seed = xs(seed);
				pulse(1 + int'(seed[5:4]));
				check("count", seen, expect_of(n, t[0]));
			end
			$display("test %0d done", t);
		end
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		complete_run();
	end
endmodule
`default_nettype wire
